//--- logic/acc_conversion_control.sv
// converter control register, trigger selection and accumulation sequencer
//
// Contract
// - trigger mode 00 starts a conversion only on a software one to busy.
// - trigger mode 01 starts a conversion on each timer 1 overflow.
// - trigger mode 10 starts only on rising edges of the convert pin.
// - trigger mode 11 starts a conversion on each timer 2 overflow.
// - done flag is set when a conversion set finishes.
// - done flag stays set until software clears it; hardware never clears it.
// - control register on page 0x00 with byte read and write plus single-bit write access.
// - repeat count selects 1, 4, 8 or 16 accumulated conversions per set.
// - without burst each conversion needs a trigger; burst self-times the set.
// - left-aligned result: high byte bits 11:4, low byte bits 3:0 then zeros.
`include "acc_defines.svh"
`default_nettype none
module acc_conversion_control
  import acc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] SFR_PAGE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic BIT_WR,
  input wire logic [7:0] BIT_ADDR,
  input wire logic BIT_VAL,
  output logic [7:0] SFR_RDATA,
  input wire logic [1:0] ACCUM_REPEAT_COUNT,
  input wire logic TMR1_OVF,
  input wire logic TMR2_OVF,
  input wire logic EXT_CONVERT_PIN,
  output logic SAR_START,
  input wire logic SAR_DONE,
  input wire logic [11:0] SAR_DATA,
  output logic CONV_DONE_FLAG
);

  // ----------------------------------------
  // register access decode
  // ----------------------------------------
  function automatic logic [7:0] apply_write(input logic [7:0] cur, input logic byte_wr,
                                              input logic [7:0] wdata, input logic bit_wr,
                                              input logic [2:0] sel, input logic val);
    logic [7:0] res;
    res = cur;
    if (byte_wr)
    begin
      res = wdata;
    end
    if (bit_wr)
    begin
      res[sel] = val;
    end
    return res;
  endfunction

  logic page_ok;
  logic ctrl_byte_wr;
  logic ctrl_bit_wr;
  logic [7:0] wr_merge;
  logic busy_wr1;
  logic done_clr;
  assign page_ok = (SFR_PAGE == `ACC_SFR_PAGE);
  assign ctrl_byte_wr = SFR_WR && page_ok && (SFR_ADDR == `ACC_ADDR_CTRL);
  assign ctrl_bit_wr = BIT_WR && page_ok && (BIT_ADDR[7:3] == 5'(`ACC_ADDR_CTRL >> 3));

  // ----------------------------------------
  // state
  // ----------------------------------------
  acc_ctrl_type ctrl_ff, nxt_ctrl;
  acc_state_type state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [15:0] acc_ff, nxt_acc;
  logic [7:0] res_hi_ff, nxt_res_hi;
  logic [7:0] res_lo_ff, nxt_res_lo;
  logic [7:0] rdata_ff, nxt_rdata;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;

  assign wr_merge = apply_write(ctrl_ff, ctrl_byte_wr, SFR_WDATA, ctrl_bit_wr, BIT_ADDR[2:0], BIT_VAL);
  // only an explicit one to busy
  assign busy_wr1 = (ctrl_bit_wr && (BIT_ADDR[2:0] == `ACC_BIT_BUSY)) ? BIT_VAL :
                    (ctrl_byte_wr && SFR_WDATA[`ACC_BIT_BUSY]);
  assign done_clr = (ctrl_byte_wr || ctrl_bit_wr) && !wr_merge[`ACC_BIT_DONE];

  // ----------------------------------------
  // trigger selection
  // ----------------------------------------
  logic ext_rise;
  logic trig;
  logic [3:0] tgt;
  logic last_conv;
  logic [15:0] acc_sum;
  assign ext_rise = ext_s2_ff && !ext_s3_ff;

  always_comb
  begin
    case (ctrl_ff.conv_trigger_sel)
      `ACC_TRIG_SOFT: trig = busy_wr1;
      `ACC_TRIG_TMR1: trig = TMR1_OVF;
      `ACC_TRIG_EXT: trig = ext_rise;
      `ACC_TRIG_TMR2: trig = TMR2_OVF;
      default: trig = 1'b0;
    endcase
    trig = trig && ctrl_ff.converter_on;
  end

  always_comb
  begin
    case (ACCUM_REPEAT_COUNT)
      `ACC_RPT_1: tgt = 4'h0;
      `ACC_RPT_4: tgt = 4'h3;
      `ACC_RPT_8: tgt = 4'h7;
      `ACC_RPT_16: tgt = 4'hF;
      default: tgt = 4'h0;
    endcase
  end

  assign last_conv = (cnt_ff == tgt);
  assign acc_sum = (cnt_ff == 4'h0) ? {4'h0, SAR_DATA} : acc_ff + {4'h0, SAR_DATA};

  // ----------------------------------------
  // sequencer and register next values
  // ----------------------------------------
  logic set_done;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_acc = acc_ff;
    nxt_res_hi = res_hi_ff;
    nxt_res_lo = res_lo_ff;
    SAR_START = 1'b0;
    set_done = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (trig)
        begin
          SAR_START = 1'b1;
          nxt_cnt = 4'h0;
          nxt_state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (SAR_DONE)
        begin
          nxt_acc = acc_sum;
          if (last_conv)
          begin
            set_done = 1'b1;
            nxt_state = ST_IDLE;
            if (ctrl_ff.left_align_sel)
            begin
              nxt_res_hi = SAR_DATA[11:4];
              nxt_res_lo = {SAR_DATA[3:0], 4'h0};
            end
            else
            begin
              nxt_res_hi = acc_sum[15:8];
              nxt_res_lo = acc_sum[7:0];
            end
          end
          else
          begin
            nxt_cnt = cnt_ff + 4'h1;
            if (ctrl_ff.burst_mode_on)
            begin
              SAR_START = 1'b1;
            end
            else
            begin
              nxt_state = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT:
      begin
        if (trig)
        begin
          SAR_START = 1'b1;
          nxt_state = ST_CONV;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_comb
  begin
    nxt_ctrl = acc_ctrl_type'(wr_merge);
    nxt_ctrl.conv_busy_bit = (nxt_state != ST_IDLE);
    nxt_ctrl.conv_done_flag = set_done || (ctrl_ff.conv_done_flag && !done_clr) ||
                              (!ctrl_ff.conv_done_flag && wr_merge[`ACC_BIT_DONE]);
    nxt_rdata = rdata_ff;
    if (SFR_RD && page_ok)
    begin
      case (SFR_ADDR)
        `ACC_ADDR_CTRL: nxt_rdata = ctrl_ff;
        `ACC_ADDR_RES_HIGH: nxt_rdata = res_hi_ff;
        `ACC_ADDR_RES_LOW: nxt_rdata = res_lo_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl_ff <= acc_ctrl_type'(`ACC_CTRL_RESET);
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      acc_ff <= 16'h0000;
      res_hi_ff <= 8'h00;
      res_lo_ff <= 8'h00;
      rdata_ff <= 8'h00;
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      acc_ff <= nxt_acc;
      res_hi_ff <= nxt_res_hi;
      res_lo_ff <= nxt_res_lo;
      rdata_ff <= nxt_rdata;
      ext_s1_ff <= EXT_CONVERT_PIN;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  assign SFR_RDATA = rdata_ff;
  assign CONV_DONE_FLAG = ctrl_ff.conv_done_flag;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  property p_soft_only;
    SAR_START && state_ff == ST_IDLE && ctrl_ff.conv_trigger_sel == `ACC_TRIG_SOFT |-> busy_wr1;
  endproperty
  a_soft_only: assert property (p_soft_only) else $error("soft mode start without busy write");

  property p_tmr1;
    state_ff == ST_IDLE && ctrl_ff.converter_on && ctrl_ff.conv_trigger_sel == `ACC_TRIG_TMR1 && TMR1_OVF
      |-> SAR_START ##1 state_ff == ST_CONV;
  endproperty
  a_tmr1: assert property (p_tmr1) else $error("timer 1 overflow did not start");

  property p_ext_edge;
    SAR_START && state_ff == ST_IDLE && ctrl_ff.conv_trigger_sel == `ACC_TRIG_EXT
      |-> $past(EXT_CONVERT_PIN, 2) && !$past(EXT_CONVERT_PIN, 3);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin start without rising edge");

  property p_tmr2;
    state_ff == ST_IDLE && ctrl_ff.converter_on && ctrl_ff.conv_trigger_sel == `ACC_TRIG_TMR2 && TMR2_OVF
      |-> SAR_START;
  endproperty
  a_tmr2: assert property (p_tmr2) else $error("timer 2 overflow did not start");

  property p_done_set;
    state_ff == ST_CONV && SAR_DONE && last_conv |=> CONV_DONE_FLAG && state_ff == ST_IDLE;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at set end");

  property p_done_sticky;
    CONV_DONE_FLAG && !done_clr |=> CONV_DONE_FLAG;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost without clear");

  property p_bit_on;
    BIT_WR && page_ok && BIT_ADDR == (`ACC_ADDR_CTRL | 8'h07) && !SFR_WR |=> ctrl_ff.converter_on == $past(BIT_VAL);
  endproperty
  a_bit_on: assert property (p_bit_on) else $error("bit write to enable not applied");

  property p_not_last;
    state_ff == ST_CONV && SAR_DONE && !last_conv |=> state_ff != ST_IDLE && ctrl_ff.conv_busy_bit;
  endproperty
  a_not_last: assert property (p_not_last) else $error("set ended before repeat count");

  property p_burst;
    state_ff == ST_CONV && SAR_DONE && !last_conv |->
      if (ctrl_ff.burst_mode_on) SAR_START else ##1 state_ff == ST_WAIT;
  endproperty
  a_burst: assert property (p_burst) else $error("burst continuation wrong");

  property p_ljst;
    state_ff == ST_CONV && SAR_DONE && last_conv && ctrl_ff.left_align_sel
      |=> res_hi_ff == $past(SAR_DATA[11:4]) && res_lo_ff == {$past(SAR_DATA[3:0]), 4'h0};
  endproperty
  a_ljst: assert property (p_ljst) else $error("left-aligned result wrong");

  property p_busy_fall;
    $fell(ctrl_ff.conv_busy_bit) |-> $past(SAR_DONE) && CONV_DONE_FLAG;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell without done");

  c_burst_set: cover property (state_ff == ST_CONV && ctrl_ff.burst_mode_on && SAR_DONE && cnt_ff == 4'hF);
  c_wait_trig: cover property (state_ff == ST_WAIT && trig);
  c_ext_start: cover property (SAR_START && ctrl_ff.conv_trigger_sel == `ACC_TRIG_EXT);
  c_set_vs_clr: cover property (set_done && done_clr);

endmodule
`default_nettype wire

//--- logic/acc_defines.svh
// address, field and reset constants for the converter control block
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_SFR_PAGE 8'h00
`define ACC_ADDR_CTRL 8'hE8
`define ACC_ADDR_RES_HIGH 8'hBE
`define ACC_ADDR_RES_LOW 8'hBD
`define ACC_CTRL_RESET 8'h00
`define ACC_BIT_ON 3'h7
`define ACC_BIT_BURST 3'h6
`define ACC_BIT_DONE 3'h5
`define ACC_BIT_BUSY 3'h4
`define ACC_BIT_WINDOW 3'h3
`define ACC_BIT_LJST 3'h2
`define ACC_TRIG_SOFT 2'h0
`define ACC_TRIG_TMR1 2'h1
`define ACC_TRIG_EXT 2'h2
`define ACC_TRIG_TMR2 2'h3
`define ACC_RPT_1 2'h0
`define ACC_RPT_4 2'h1
`define ACC_RPT_8 2'h2
`define ACC_RPT_16 2'h3
`endif

//--- logic/acc_pkg.sv
// types shared by the converter control block
`default_nettype none
package acc_pkg;
  typedef struct packed {
    logic converter_on;
    logic burst_mode_on;
    logic conv_done_flag;
    logic conv_busy_bit;
    logic window_match_flag;
    logic left_align_sel;
    logic [1:0] conv_trigger_sel;
  } acc_ctrl_type;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} acc_state_type;
endpackage
`default_nettype wire

//--- verification/acc_conversion_control_tb_top.sv
// self-checking bench for the converter control block
`default_nettype none
`define ACC_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module acc_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acc_pkg::*;
  logic clk, rstn, sfr_wr, sfr_rd, bit_wr, bit_val, tmr1, tmr2, ext, sar_start, sar_done, conv_done;
  logic [7:0] page, sfr_addr, sfr_wdata, bit_addr, sfr_rdata;
  logic [1:0] rpt;
  logic [11:0] value, sar_data;
  int err_count, checks_done, starts, s0;
  acc_conversion_control dut (.CLK(clk), .RSTN(rstn), .SFR_PAGE(page), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .BIT_WR(bit_wr), .BIT_ADDR(bit_addr),
    .BIT_VAL(bit_val), .SFR_RDATA(sfr_rdata), .ACCUM_REPEAT_COUNT(rpt), .TMR1_OVF(tmr1),
    .TMR2_OVF(tmr2), .EXT_CONVERT_PIN(ext), .SAR_START(sar_start), .SAR_DONE(sar_done),
    .SAR_DATA(sar_data), .CONV_DONE_FLAG(conv_done));
  acc_sar_model #(.LAT(6)) core (.clk(clk), .rstn(rstn), .start(sar_start), .value(value),
    .done(sar_done), .data(sar_data));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (sar_start === 1'b1)
      starts++;
  // ----------------------------------------
  // bus and trigger tasks
  // ----------------------------------------
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic wr_bit(input logic [2:0] b, input logic v);
    @(negedge clk);
    bit_wr = 1'b1;
    bit_addr = {5'h1D, b};
    bit_val = v;
    @(negedge clk);
    bit_wr = 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge clk);
    sfr_rd = 1'b0;
    `ACC_CHK(sfr_rdata, exp)
  endtask
  task automatic trig(input int src);
    case (src)
      0: wr_bit(3'h4, 1'b1);
      1: begin @(negedge clk); tmr1 = 1'b1; @(negedge clk); tmr1 = 1'b0; end
      2: begin @(negedge clk); ext = 1'b1; repeat (5) @(negedge clk); ext = 1'b0; repeat (5) @(negedge clk); end
      default: begin @(negedge clk); tmr2 = 1'b1; @(negedge clk); tmr2 = 1'b0; end
    endcase
  endtask
  task automatic wait_conv(input int n);
    repeat (n * 9) @(negedge clk);
  endtask
  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #125000;
    err_count++;
    test_done;
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    {rstn, sfr_wr, sfr_rd, bit_wr, bit_val, tmr1, tmr2, ext} = '0;
    {page, sfr_addr, sfr_wdata, bit_addr, rpt} = '0;
    value = 12'h5A5;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    chk_rd(8'hE8, 8'h00);
    chk_rd(8'hBE, 8'h00);
    wr_byte(8'hE8, 8'h04);
    wr_bit(3'h3, 1'b1);
    wr_bit(3'h7, 1'b1);
    chk_rd(8'hE8, 8'h8C);
    wr_bit(3'h7, 1'b0);
    page = 8'h01;
    wr_byte(8'hE8, 8'hFF);
    chk_rd(8'hE8, 8'h8C);
    page = 8'h00;
    chk_rd(8'hE8, 8'h0C);
    end_test("registers");
    for (int m = 0; m < 4; m++)
    begin
      wr_byte(8'hE8, 8'h80 | 8'(m));
      s0 = starts;
      for (int s = 0; s < 4; s++)
        if (s != m)
          trig(s);
      `ACC_CHK(starts, s0)
      trig(m);
      wait_conv(1);
      `ACC_CHK(starts, s0 + 1)
      `ACC_CHK(conv_done, 1'b1)
    end
    end_test("triggers");
    wr_byte(8'hE8, 8'h80);
    trig(0);
    chk_rd(8'hE8, 8'h90);
    wait_conv(1);
    chk_rd(8'hE8, 8'hA0);
    chk_rd(8'hBE, 8'h05);
    chk_rd(8'hBD, 8'hA5);
    wait_conv(3);
    chk_rd(8'hE8, 8'hA0);
    wr_bit(3'h5, 1'b0);
    `ACC_CHK(conv_done, 1'b0)
    end_test("sticky");
    rpt = 2'h1;
    wr_byte(8'hE8, 8'h80);
    trig(0);
    wait_conv(1);
    s0 = starts;
    wr_bit(3'h3, 1'b0);
    wait_conv(1);
    `ACC_CHK(starts, s0)
    repeat (3)
    begin
      trig(0);
      wait_conv(1);
    end
    `ACC_CHK(starts, s0 + 3)
    `ACC_CHK(conv_done, 1'b1)
    end_test("soft set");
    rpt = 2'h1;
    value = 12'h123;
    wr_byte(8'hE8, 8'h81);
    repeat (3)
    begin
      trig(1);
      wait_conv(1);
    end
    `ACC_CHK(conv_done, 1'b0)
    trig(1);
    wait_conv(1);
    `ACC_CHK(conv_done, 1'b1)
    chk_rd(8'hBE, 8'h04);
    chk_rd(8'hBD, 8'h8C);
    rpt = 2'h3;
    value = 12'hFFF;
    wr_byte(8'hE8, 8'hC1);
    s0 = starts;
    trig(1);
    wait_conv(16);
    `ACC_CHK(starts, s0 + 16)
    chk_rd(8'hE8, 8'hE1);
    chk_rd(8'hBE, 8'hFF);
    chk_rd(8'hBD, 8'hF0);
    end_test("accumulate");
    rpt = 2'h0;
    value = 12'hABC;
    wr_byte(8'hE8, 8'h84);
    trig(0);
    wait_conv(1);
    chk_rd(8'hBE, 8'hAB);
    chk_rd(8'hBD, 8'hC0);
    end_test("align");
    test_done;
  end
endmodule
`undef ACC_CHK
`default_nettype wire

//--- verification/acc_sar_model.sv
// behavioural analog converter core answering start pulses
`default_nettype none
module acc_sar_model
  import acc_pkg::*;
#(
  parameter int LAT = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [11:0] value,
  output logic done,
  output logic [11:0] data
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_ff;
  int nxt_cnt;
  // a new start restarts the count
  always_comb
  begin
    nxt_cnt = (cnt_ff != 0) ? cnt_ff - 1 : 0;
    if (start)
      nxt_cnt = LAT;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_ff <= 0;
    else
      cnt_ff <= nxt_cnt;
  end
  assign done = (cnt_ff == 1);
  // data only valid with the done pulse
  assign data = done ? value : ~value;
endmodule
`default_nettype wire
